// ===== hw/dmc_channels.sv
// dmc_channels: four-channel engine running minor loops and handling
// major-loop completion (adjust, scatter/gather reload, link, done).
// assumes an AHB-Lite master for registers and a memory port whose m_ack
// is a one-cycle pulse answering a held m_req.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dmc_channels
  import dmc_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             m_req,
  output logic             m_write,
  output logic      [31:0] m_addr,
  output logic      [31:0] m_wdata,
  input  wire logic        m_ack,
  input  wire logic [31:0] m_rdata,
  output logic             dma_irq
);

  // the link target field is two bits wide, so exactly four channels
  if (NCH != 4) begin : g_chk
    $error("dmc_channels supports NCH = 4 only");
  end

  ////////////////////////////////////////////////////////////////////////////
  dmc_state_t  state_r, state_nxt, ret_r, ret_nxt;
  logic [1:0]  cur_r, cur_nxt, pick;
  logic [15:0] cnt_r, cnt_nxt;
  logic        first_r, first_nxt;
  logic [31:0] buf_r, buf_nxt;
  logic [2:0]  sgk_r, sgk_nxt;
  logic [31:0] saddr_r [NCH];
  logic [31:0] saddr_nxt [NCH];
  logic [31:0] daddr_r [NCH];
  logic [31:0] daddr_nxt [NCH];
  logic [31:0] dlast_r [NCH];
  logic [31:0] dlast_nxt [NCH];
  logic [16:0] minor_r [NCH];
  logic [16:0] minor_nxt [NCH];
  logic [15:0] iter_r [NCH];
  logic [15:0] iter_nxt [NCH];
  logic [1:0]  link_r [NCH];
  logic [1:0]  link_nxt [NCH];
  logic [1:0]  thr_r [NCH];
  logic [1:0]  thr_nxt [NCH];
  logic [NCH-1:0] start_r, start_nxt, sge_r, sge_nxt, elink_r, elink_nxt;
  logic [NCH-1:0] active_r, active_nxt, done_r, done_nxt;
  logic [7:0]  sts_r, sts_nxt, msk_r, msk_nxt;
  logic        irq_r, irq_nxt;
  logic        req_r, req_nxt, we_r, we_nxt;
  logic [31:0] maddr_r, maddr_nxt, mwdata_r, mwdata_nxt;
  logic        wpend_r, wpend_nxt;
  logic [15:0] wadr_r, wadr_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [1:0]  iss;
  logic        sst, thr_last, ahb_go, rd_csr;
  logic [1:0]  rch, wch, cur_link, cur_thr;
  logic [15:0] roff, woff;
  logic [31:0] cur_daddr, cur_dlast;
  logic        cur_szeq, cur_last, cur_stall;

  assign ahb_go    = hsel && htrans[1] && hready;
  assign rch       = haddr[6:5];
  assign roff      = {haddr[15:7], 2'h0, haddr[4:0]};
  assign wch       = wadr_r[6:5];
  assign woff      = {wadr_r[15:7], 2'h0, wadr_r[4:0]};
  assign rd_csr    = ahb_go && !hwrite && roff == OFS_CSR;
  assign cur_link  = link_r[cur_r];
  assign cur_thr   = thr_r[cur_r];
  assign cur_daddr = daddr_r[cur_r];
  assign cur_dlast = dlast_r[cur_r];
  assign cur_szeq  = minor_r[cur_r][MINOR_SZEQ];
  assign cur_last  = iter_r[cur_r] <= 16'h0001;
  assign cur_stall = cur_thr[1];

  dmc_throttle u_thr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (sst),
    .code    (cur_thr),
    .last    (thr_last)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;   ret_nxt = ret_r;     cur_nxt = cur_r;
    cnt_nxt = cnt_r;       first_nxt = first_r; buf_nxt = buf_r;
    sgk_nxt = sgk_r;       saddr_nxt = saddr_r; daddr_nxt = daddr_r;
    dlast_nxt = dlast_r;   minor_nxt = minor_r; iter_nxt = iter_r;
    link_nxt = link_r;     thr_nxt = thr_r;     start_nxt = start_r;
    sge_nxt = sge_r;       elink_nxt = elink_r; active_nxt = active_r;
    done_nxt = done_r;     sts_nxt = sts_r;     msk_nxt = msk_r;
    req_nxt = req_r;       we_nxt = we_r;       maddr_nxt = maddr_r;
    mwdata_nxt = mwdata_r; rdat_nxt = rdat_r;
    iss = 2'h0;
    sst = 1'b0;
    pick = 2'h0;
    // address phase: latch word writes (hsize 2) only, answer reads with zero wait states
    wpend_nxt = ahb_go && hwrite && hsize == 3'h2;
    wadr_nxt = ahb_go ? haddr[15:0] : wadr_r;
    if (ahb_go && !hwrite) begin
      rdat_nxt = RST_WORD;
      if (haddr[15:0] == OFS_STATUS) begin
        rdat_nxt = {24'h000000, sts_r};
        sts_nxt = RST_BYTE;
      end else if (haddr[15:0] == OFS_MASK) begin
        rdat_nxt = {24'h000000, msk_r};
      end else begin
        case (roff)
          OFS_SADDR: rdat_nxt = saddr_r[rch];
          OFS_MINOR: rdat_nxt = {15'h0000, minor_r[rch]};
          OFS_DADDR: rdat_nxt = daddr_r[rch];
          OFS_ITER:  rdat_nxt = {16'h0000, iter_r[rch]};
          OFS_DLAST: rdat_nxt = dlast_r[rch];
          OFS_CSR:   rdat_nxt = {16'h0000, thr_r[rch], 4'h0, link_r[rch], done_r[rch],
                                 active_r[rch], elink_r[rch], sge_r[rch], 3'h0,
                                 start_r[rch]};
          default:   rdat_nxt = RST_WORD;
        endcase
      end
    end
    // data phase of a write
    if (wpend_r) begin
      if (wadr_r == OFS_MASK) begin
        msk_nxt = hwdata[7:0];
      end else if (wadr_r != OFS_STATUS) begin
        case (woff)
          OFS_SADDR: saddr_nxt[wch] = hwdata;
          OFS_MINOR: minor_nxt[wch] = hwdata[16:0];
          OFS_DADDR: daddr_nxt[wch] = hwdata;
          OFS_ITER:  iter_nxt[wch] = hwdata[15:0];
          OFS_DLAST: dlast_nxt[wch] = hwdata;
          OFS_CSR: begin
            thr_nxt[wch] = hwdata[CSR_THR_LO +: 2];
            link_nxt[wch] = hwdata[CSR_LINK_LO +: 2];
            elink_nxt[wch] = hwdata[CSR_ELINK] && !done_r[wch];
            sge_nxt[wch] = hwdata[CSR_SGE] && !done_r[wch];
            done_nxt[wch] = done_r[wch] && hwdata[CSR_DONE];
            start_nxt[wch] = start_r[wch] || hwdata[CSR_START];
          end
          default: ;
        endcase
      end
    end
    // engine; hardware sets come after software clears so that they win
    case (state_r)
      S_IDLE: begin
        for (int i = NCH - 1; i >= 0; i--) begin
          if (start_r[i]) begin
            pick = 2'(i);
          end
        end
        if (start_r != '0) begin
          cur_nxt = pick;
          start_nxt[pick] = 1'b0;
          active_nxt[pick] = 1'b1;
          done_nxt[pick] = 1'b0;
          cnt_nxt = minor_r[pick][15:0];
          first_nxt = 1'b1;
          if (minor_r[pick][15:0] == 16'h0000) begin
            state_nxt = S_CPL;
          end else begin
            state_nxt = S_RD;
            iss = 2'h1;
          end
        end
      end
      S_RD: begin
        if (m_ack) begin
          buf_nxt = m_rdata;
          req_nxt = 1'b0;
          saddr_nxt[cur_r] = saddr_r[cur_r] + WORD_STEP;
          if (cur_stall && !(cur_szeq && first_r)) begin
            state_nxt = S_STALL;
            ret_nxt = S_WR;
            sst = 1'b1;
          end else begin
            state_nxt = S_WR;
            iss = 2'h2;
          end
        end
      end
      S_WR: begin
        if (m_ack) begin
          req_nxt = 1'b0;
          first_nxt = 1'b0;
          daddr_nxt[cur_r] = daddr_r[cur_r] + WORD_STEP;
          cnt_nxt = cnt_r - 16'h0001;
          ret_nxt = (cnt_r == 16'h0001) ? S_CPL : S_RD;
          if (cur_stall && !(cnt_r == 16'h0001 && cur_szeq)) begin
            state_nxt = S_STALL;
            sst = 1'b1;
          end else if (cnt_r == 16'h0001) begin
            state_nxt = S_CPL;
          end else begin
            state_nxt = S_RD;
            iss = 2'h1;
          end
        end
      end
      S_STALL: begin
        if (thr_last) begin
          state_nxt = ret_r;
          iss = (ret_r == S_RD) ? 2'h1 : (ret_r == S_WR) ? 2'h2 : 2'h0;
        end
      end
      S_CPL: begin
        active_nxt[cur_r] = 1'b0;
        state_nxt = S_IDLE;
        iter_nxt[cur_r] = cur_last ? 16'h0000 : iter_r[cur_r] - 16'h0001;
        if (cur_last) begin
          done_nxt[cur_r] = 1'b1;
          sts_nxt[STS_DONE_LO + 32'(cur_r)] = 1'b1;
          if (elink_r[cur_r]) begin
            start_nxt[cur_link] = 1'b1;
          end
          if (sge_r[cur_r]) begin
            if (cur_dlast[SG_ALIGN_BITS-1:0] == 5'h00) begin
              state_nxt = S_SG;
              sgk_nxt = 3'h0;
              req_nxt = 1'b1;
              we_nxt = 1'b0;
              maddr_nxt = cur_dlast;
            end
          end else begin
            daddr_nxt[cur_r] = 32'($signed(cur_daddr) + $signed(cur_dlast));
          end
        end
      end
      S_SG: begin
        if (m_ack) begin
          case (sgk_r)
            3'h0: saddr_nxt[cur_r] = m_rdata;
            3'h2: minor_nxt[cur_r] = m_rdata[16:0];
            3'h4: daddr_nxt[cur_r] = m_rdata;
            3'h5: iter_nxt[cur_r] = m_rdata[15:0];
            3'h6: dlast_nxt[cur_r] = m_rdata;
            3'h7: begin
              thr_nxt[cur_r] = m_rdata[CSR_THR_LO +: 2];
              link_nxt[cur_r] = m_rdata[CSR_LINK_LO +: 2];
              elink_nxt[cur_r] = m_rdata[CSR_ELINK];
              sge_nxt[cur_r] = m_rdata[CSR_SGE];
              start_nxt[cur_r] = m_rdata[CSR_START];
            end
            default: ;
          endcase
          sgk_nxt = sgk_r + 3'h1;
          maddr_nxt = maddr_r + WORD_STEP;
          if (sgk_r == SG_LAST) begin
            req_nxt = 1'b0;
            state_nxt = S_IDLE;
          end
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    // a misaligned pointer is reported for as long as it stands
    for (int i = 0; i < NCH; i++) begin
      if (sge_r[i] && dlast_r[i][SG_ALIGN_BITS-1:0] != 5'h00) begin
        sts_nxt[STS_ERR_LO + i] = 1'b1;
      end
    end
    if (iss == 2'h1) begin
      req_nxt = 1'b1;
      we_nxt = 1'b0;
      maddr_nxt = saddr_nxt[cur_nxt];
    end else if (iss == 2'h2) begin
      req_nxt = 1'b1;
      we_nxt = 1'b1;
      maddr_nxt = daddr_nxt[cur_nxt];
      mwdata_nxt = buf_nxt;
    end
    irq_nxt = |(sts_nxt & msk_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;   ret_r <= S_IDLE;   cur_r <= 2'h0;
      cnt_r <= 16'h0000;   first_r <= 1'b0;   buf_r <= RST_WORD;
      sgk_r <= 3'h0;       start_r <= '0;     sge_r <= '0;
      elink_r <= '0;       active_r <= '0;    done_r <= '0;
      sts_r <= RST_BYTE;   msk_r <= RST_BYTE; irq_r <= 1'b0;
      req_r <= 1'b0;       we_r <= 1'b0;      maddr_r <= RST_WORD;
      mwdata_r <= RST_WORD; wpend_r <= 1'b0;  wadr_r <= 16'h0000;
      rdat_r <= RST_WORD;
      for (int i = 0; i < NCH; i++) begin
        saddr_r[i] <= RST_WORD; daddr_r[i] <= RST_WORD; dlast_r[i] <= RST_WORD;
        minor_r[i] <= 17'h00000; iter_r[i] <= 16'h0000;
        link_r[i] <= 2'h0;       thr_r[i] <= THR_NONE;
      end
    end else begin
      state_r <= state_nxt; ret_r <= ret_nxt;     cur_r <= cur_nxt;
      cnt_r <= cnt_nxt;     first_r <= first_nxt; buf_r <= buf_nxt;
      sgk_r <= sgk_nxt;     start_r <= start_nxt; sge_r <= sge_nxt;
      elink_r <= elink_nxt; active_r <= active_nxt; done_r <= done_nxt;
      sts_r <= sts_nxt;     msk_r <= msk_nxt;     irq_r <= irq_nxt;
      req_r <= req_nxt;     we_r <= we_nxt;       maddr_r <= maddr_nxt;
      mwdata_r <= mwdata_nxt; wpend_r <= wpend_nxt; wadr_r <= wadr_nxt;
      rdat_r <= rdat_nxt;   saddr_r <= saddr_nxt; daddr_r <= daddr_nxt;
      dlast_r <= dlast_nxt; minor_r <= minor_nxt; iter_r <= iter_nxt;
      link_r <= link_nxt;   thr_r <= thr_nxt;
    end
  end

  // the slave never inserts wait states and always answers OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata  = rdat_r;
  assign m_req   = req_r;
  assign m_write = we_r;
  assign m_addr  = maddr_r;
  assign m_wdata = mwdata_r;
  assign dma_irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_adjust;
    state_r == S_CPL && cur_last && !sge_r[cur_r] && !wpend_r
    |=> daddr_r[$past(cur_r)] == 32'($past(cur_daddr) + $past(cur_dlast));
  endproperty
  a_adjust: assert property (p_adjust) else $error("final adjust not applied");

  property p_sg_fetch;
    state_r == S_CPL && cur_last && sge_r[cur_r] && cur_dlast[4:0] == 5'h00
    |=> state_r == S_SG && m_req && !m_write && m_addr == $past(cur_dlast);
  endproperty
  a_sg_fetch: assert property (p_sg_fetch) else $error("reload not started");

  property p_misalign;
    sge_r[2] && dlast_r[2][4:0] != 5'h00 |=> sts_r[STS_ERR_LO + 2];
  endproperty
  a_misalign: assert property (p_misalign) else $error("config error missing");

  property p_stall8;
    state_r == S_WR && m_ack && cnt_r != 16'h0001 && cur_thr == THR_8
    |=> (state_r == S_STALL)[*8] ##1 (state_r == S_RD && m_req);
  endproperty
  a_stall8: assert property (p_stall8) else $error("eight-cycle stall wrong");

  property p_stall4;
    state_r == S_WR && m_ack && cnt_r != 16'h0001 && cur_thr == THR_4
    |=> (state_r == S_STALL)[*4] ##1 state_r == S_RD;
  endproperty
  a_stall4: assert property (p_stall4) else $error("four-cycle stall wrong");

  property p_szeq_skip;
    state_r == S_RD && m_ack && first_r && cur_szeq |=> state_r == S_WR && m_write;
  endproperty
  a_szeq_skip: assert property (p_szeq_skip) else $error("stall not skipped");

  property p_nostall;
    state_r == S_WR && m_ack && cnt_r != 16'h0001 && cur_thr == THR_NONE
    |=> state_r == S_RD && m_req && !m_write;
  endproperty
  a_nostall: assert property (p_nostall) else $error("gap between accesses");

  property p_nolink;
    state_r == S_CPL && !elink_r[cur_r] && start_r == '0 && !wpend_r |=> start_r == '0;
  endproperty
  a_nolink: assert property (p_nolink) else $error("link without enable");

  property p_link;
    state_r == S_CPL && cur_last && elink_r[cur_r] |=> start_r[$past(cur_link)];
  endproperty
  a_link: assert property (p_link) else $error("link target not started");

  property p_done;
    state_r == S_CPL && cur_last |=> done_r[$past(cur_r)] && dma_irq == |(sts_r & msk_r);
  endproperty
  a_done: assert property (p_done) else $error("done not set");

  property p_activate;
    state_r == S_IDLE && start_r != '0 |=> !done_r[cur_r] && active_r[cur_r];
  endproperty
  a_activate: assert property (p_activate) else $error("done kept on activation");

  property p_reserved;
    rd_csr |=> hrdata[13:10] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_force;
    wpend_r && woff == OFS_CSR && wadr_r != OFS_STATUS && done_r[wch] && state_r != S_SG
    |=> !sge_r[$past(wch)] && !elink_r[$past(wch)];
  endproperty
  a_force: assert property (p_force) else $error("enable written while done");

  c_sg: cover property (state_r == S_SG && m_ack && sgk_r == SG_LAST);
  c_stall: cover property (state_r == S_STALL && thr_last);
  c_link: cover property (state_r == S_CPL && cur_last && elink_r[cur_r]);
  c_irq: cover property (!dma_irq ##1 dma_irq);

endmodule

// ===== hw/dmc_throttle.sv
// dmc_throttle: post-access stall counter for the bandwidth throttle.
// assumes start is a one-cycle pulse from the engine on the same clock.
`timescale 1ns/1ps
module dmc_throttle
  import dmc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       start,
  input  wire logic [1:0] code,
  output logic            last
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      // reserved code 01 is served as no stall
      case (code)
        THR_4:   cnt_nxt = STALL_SHORT;
        THR_8:   cnt_nxt = STALL_LONG;
        default: cnt_nxt = 4'h0;
      endcase
    end else if (cnt_r != 4'h0) begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign last = (cnt_r == 4'h1);

endmodule

// ===== pkg/dmc_pkg.sv
// dmc_pkg: offsets, field positions, reset values, stall counts and states
// of the four-channel major-loop completion engine.
// assumes one clock (hclk, 100 MHz) and an AHB-Lite slave for software access.
// Functional notes
// - with scatter/gather off, the last-destination adjustment is added to the destination address at major-loop end.
// - the adjustment is a signed 32-bit two's complement value, so the address may move either way.
// - with scatter/gather on, the same word is the address of the next descriptor, reloaded at major-loop end.
// - scatter/gather on with a pointer not on a 32-byte boundary raises a configuration error.
// - the two-bit throttle field stalls after each read or write: 00 none, 10 four cycles, 11 eight, 01 reserved.
// - with equal source and destination sizes, no stall after the first read nor after the last write of a minor loop.
// - a minor loop issues read/write pairs back to back until its count is spent, unless the throttle stalls between them.
// - with major link disabled, no channel is started at major-loop end whatever the target field holds.
// - with major link enabled, the target channel's start bit is set at major-loop end.
// - the done flag is set when the current iteration count reaches zero.
// - done is cleared by a software write and by hardware when the channel is next activated.
// - control/status bits 13 to 10 are reserved, read zero and do nothing.
// - each channel's descriptor words repeat at a 32-byte stride, last-adjust word at 0x1018, channels 0 to 3.
// - the scatter/gather bit chooses at major-loop end between a descriptor reload and the final adjustment.
// - a write to major link enable or scatter/gather enable forces that bit to zero while done is set.
package dmc_pkg;

  localparam logic [15:0] OFS_STATUS = 16'h0000;
  localparam logic [15:0] OFS_MASK   = 16'h0004;
  localparam logic [15:0] OFS_SADDR  = 16'h1000;
  localparam logic [15:0] OFS_MINOR  = 16'h1008;
  localparam logic [15:0] OFS_DADDR  = 16'h1010;
  localparam logic [15:0] OFS_ITER   = 16'h1014;
  localparam logic [15:0] OFS_DLAST  = 16'h1018;
  localparam logic [15:0] OFS_CSR    = 16'h101C;

  localparam int CSR_START   = 0;
  localparam int CSR_SGE     = 4;
  localparam int CSR_ELINK   = 5;
  localparam int CSR_DONE    = 7;
  localparam int CSR_LINK_LO = 8;
  localparam int CSR_THR_LO  = 14;
  localparam int MINOR_SZEQ  = 16;
  localparam int STS_DONE_LO = 0;
  localparam int STS_ERR_LO  = 4;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  localparam logic [1:0] THR_NONE = 2'h0;
  localparam logic [1:0] THR_4    = 2'h2;
  localparam logic [1:0] THR_8    = 2'h3;
  localparam logic [3:0] STALL_SHORT = 4'h4;
  localparam logic [3:0] STALL_LONG  = 4'h8;

  localparam int SG_ALIGN_BITS = 5;
  localparam logic [2:0] SG_LAST = 3'h7;

  typedef enum logic [2:0] {S_IDLE, S_RD, S_WR, S_STALL, S_CPL, S_SG} dmc_state_t;

endpackage

// ===== sim/dmc_mem_model.sv
// dmc_mem_model: word memory answering the engine's master port.
// assumes byte addresses below 0x400 and one access at a time.
`timescale 1ns/1ps
module dmc_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        m_req,
  input  wire logic        m_write,
  input  wire logic [31:0] m_addr,
  input  wire logic [31:0] m_wdata,
  input  wire logic [3:0]  lat,
  output logic             m_ack,
  output logic      [31:0] m_rdata
);
  logic [31:0] mem [0:255];
  logic [31:0] alog [0:15];
  int          gap [0:15];
  int          n_acc = 0;
  int          idle;
  int          wc;
  logic        busy;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_ack <= 1'b0;
      m_rdata <= 32'h0;
      busy = 1'b0;
      idle = 0;
    end else if (m_ack) begin
      m_ack <= 1'b0;
      // data is stale once taken, so never leave it looking valid
      m_rdata <= ~m_rdata;
      busy = 1'b0;
    end else if (m_req) begin
      if (!busy) begin
        gap[n_acc & 15] = idle;
        alog[n_acc & 15] = m_addr;
        n_acc = n_acc + 1;
        busy = 1'b1;
        idle = 0;
        wc = 0;
      end
      if (wc >= lat) begin
        m_ack <= 1'b1;
        if (m_write)
          mem[m_addr[9:2]] = m_wdata;
        else
          m_rdata <= mem[m_addr[9:2]];
      end
      wc = wc + 1;
    end else begin
      idle = idle + 1;
    end
  end
endmodule

// ===== sim/tb.sv
// tb: drives the register bus and checks completion behaviour.
// assumes dmc_mem_model on the master port.
`timescale 1ns/1ps
module tb import dmc_pkg::*; ;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, m_addr, m_wdata, m_rdata, q;
  logic        hreadyout, hresp, m_req, m_write, m_ack, dma_irq;
  logic [3:0]  lat = 4'h0;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  logic [1:0]  bw_code [0:3] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int          bw_gap [0:3][0:2] = '{'{0, 0, 0}, '{0, 0, 0}, '{8, 8, 8}, '{0, 4, 4}};
  dmc_channels #(.NCH(4)) i_dmc_channels (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .m_req, .m_write, .m_addr, .m_wdata, .m_ack, .m_rdata, .dma_irq);
  dmc_mem_model i_dmc_mem_model (.hclk, .hresetn, .m_req, .m_write, .m_addr,
    .m_wdata, .lat, .m_ack, .m_rdata);
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk);
    while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk);
    while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rc(input logic [31:0] a, input string nm, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  function automatic logic [31:0] ra(input int c, input logic [15:0] o);
    return {16'h0, o} + 32'(32 * c);
  endfunction
  task automatic wv(input logic [31:0] a, input logic [31:0] m);
    do ahb(1'b0, a, 32'h0);
    while ((q & m) == 32'h0);
  endtask
  // clearing done first keeps the enables from being forced off
  task automatic run(input int c, input logic [31:0] mn, input logic [31:0] dl,
                     input logic [31:0] cs);
    ahb(1'b1, ra(c, OFS_SADDR), 32'h100);
    ahb(1'b1, ra(c, OFS_DADDR), 32'h200);
    ahb(1'b1, ra(c, OFS_MINOR), mn);
    ahb(1'b1, ra(c, OFS_ITER), 32'h1);
    ahb(1'b1, ra(c, OFS_DLAST), dl);
    ahb(1'b1, ra(c, OFS_CSR), cs);
    i_dmc_mem_model.n_acc = 0;
    ahb(1'b1, ra(c, OFS_CSR), cs | 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rc(ra(0, OFS_CSR), "csr_reset", 32'h0);
    ahb(1'b1, ra(3, OFS_DLAST), 32'h1234_5678);
    rc(ra(3, OFS_DLAST), "dlast3", 32'h1234_5678);
    rc(ra(0, OFS_DLAST), "dlast0", 32'h0);
    ahb(1'b1, 32'h0000_0800, 32'hFFFF_FFFF);
    rc(32'h0000_0800, "unmapped", 32'h0);
  endtask
  task automatic t_adj();
    i_dmc_mem_model.mem[8'h40] = 32'hA5A5_0001;
    i_dmc_mem_model.mem[8'h41] = 32'h5A5A_0002;
    lat <= 4'h2;
    run(0, 32'h2, 32'hFFFF_FFF0, 32'h0);
    wv(ra(0, OFS_CSR), 32'h80);
    chk("irq_masked", 32'h0, {31'h0, dma_irq});
    rc(ra(0, OFS_DADDR), "daddr", 32'h1F8);
    chk("wr0", 32'hA5A5_0001, i_dmc_mem_model.mem[8'h80]);
    chk("wr1", 32'h5A5A_0002, i_dmc_mem_model.mem[8'h81]);
    chk("accesses", 32'h4, 32'(i_dmc_mem_model.n_acc));
    rc(ra(0, OFS_STATUS), "status", 32'h1);
    ahb(1'b1, ra(0, OFS_MASK), 32'h1);
    run(0, 32'h1, 32'h0, 32'h0);
    wv(ra(0, OFS_CSR), 32'h80);
    chk("irq_set", 32'h1, {31'h0, dma_irq});
    rc(ra(0, OFS_STATUS), "status", 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_clear", 32'h0, {31'h0, dma_irq});
    lat <= 4'h0;
  endtask
  task automatic t_bwc();
    for (int k = 0; k < 4; k++) begin
      run(0, {15'h0, 1'(k == 3), 16'h2}, 32'h0, {16'h0, bw_code[k], 14'h0});
      wv(ra(0, OFS_CSR), 32'h80);
      for (int j = 1; j < 4; j++)
        chk("gap", 32'(bw_gap[k][j-1]), 32'(i_dmc_mem_model.gap[j]));
    end
  endtask
  task automatic t_link();
    run(0, 32'h0, 32'h0, 32'h300);
    wv(ra(0, OFS_CSR), 32'h80);
    ahb(1'b1, ra(0, OFS_CSR), 32'h3CB0);
    rc(ra(0, OFS_CSR), "csr_forced", 32'h80);
    rc(ra(3, OFS_CSR), "no_link", 32'h0);
    ahb(1'b1, ra(0, OFS_CSR), 32'h0);
    rc(ra(0, OFS_CSR), "done_clear", 32'h0);
    run(0, 32'h0, 32'h0, 32'h220);
    wv(ra(2, OFS_CSR), 32'h80);
    rc(ra(2, OFS_CSR), "linked", 32'h80);
  endtask
  task automatic t_sg();
    for (int i = 0; i < 8; i++)
      i_dmc_mem_model.mem[8'hC0 + i] = 32'h0;
    i_dmc_mem_model.mem[8'hC4] = 32'h400;
    run(1, 32'h0, 32'h300, 32'h10);
    wv(ra(0, OFS_STATUS), 32'h2);
    while (i_dmc_mem_model.n_acc < 8)
      @(posedge hclk);
    rc(ra(1, OFS_DADDR), "sg_dest", 32'h400);
    chk("sg_reads", 32'h8, 32'(i_dmc_mem_model.n_acc));
    for (int i = 0; i < 8; i++)
      chk("sg_addr", 32'h300 + 32'(4 * i), i_dmc_mem_model.alog[i]);
    run(2, 32'h0, 32'h304, 32'h10);
    wv(ra(0, OFS_STATUS), 32'h40);
    chk("sg_err", 32'h40, q & 32'h40);
    ahb(1'b1, ra(2, OFS_CSR), 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_adj();
    t_bwc();
    t_link();
    t_sg();
    summarize();
  end
endmodule
